// >>> dv/pd_cc_checker_asserts.sv
// Concurrent checks on the ports of the CC transceiver and attach detector.
`timescale 1ns/1ps
module pd_cc_checker
  import pd_cc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic                 I_CLOCK,
  input wire logic                 I_RST,
  input wire logic [ADV_W-1:0]     I_ADV_CURRENT,
  input wire logic [TX_PEAK_W-1:0] I_TX_PEAK_LEVEL,
  input wire logic                 I_LINE_A_BELOW_CABLE,
  input wire logic                 I_LINE_B_BELOW_SINK,
  input wire logic                 I_LINE_B_BELOW_CABLE,
  // Outputs
  input wire logic                 O_TX_READY,
  input wire logic                 O_TX_BUSY,
  input wire logic                 O_RX_ACTIVE,
  input wire logic                 O_LINE_A_TX,
  input wire logic                 O_LINE_A_TX_OE,
  input wire logic                 O_LINE_B_TX_OE,
  input wire logic [TX_PEAK_W-1:0] O_TX_PEAK_LEVEL,
  input wire logic [ADV_W-1:0]     O_PULLUP_SELECT,
  input wire logic                 O_VBUS_EN,
  input wire logic                 O_VCONN_A_EN,
  input wire logic                 O_VCONN_B_EN,
  input wire logic                 O_ORIENT_B,
  input wire logic                 O_ATTACHED,
  input wire logic [1:0]           O_LINE_A_CODE,
  input wire logic [1:0]           O_LINE_B_CODE
);
  logic       prev_level;
  logic [9:0] run;

  // Saturating run length of the line level, so idle gaps never wrap.
  always_ff @(posedge I_CLOCK) begin
    prev_level <= O_LINE_A_TX;
    if (I_RST) begin
      run <= 10'h3ff;
    end else if (O_LINE_A_TX != prev_level) begin
      run <= 10'h000;
    end else if (run != 10'h3ff) begin
      run <= run + 10'h001;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  a_one_driver: assert property (!(O_LINE_A_TX_OE && O_LINE_B_TX_OE))
    else $error("both line drivers enabled");
  a_drive_busy: assert property ((O_LINE_A_TX_OE || O_LINE_B_TX_OE)
    |-> O_TX_BUSY) else $error("driver enabled while not sending");
  a_drive_oriented: assert property ((O_LINE_A_TX_OE |-> !O_ORIENT_B)
    and (O_LINE_B_TX_OE |-> O_ORIENT_B)) else $error("wrong line driven");
  a_preamble_low: assert property ($rose(O_LINE_A_TX_OE ||
    O_LINE_B_TX_OE) |-> !O_LINE_A_TX) else $error("frame starts high");
  a_half_bit_len: assert property ((O_LINE_A_TX != prev_level)
    |-> run >= 10'h0a4) else $error("line edge too early");
  a_vconn_ra_line: assert property ((O_VCONN_A_EN |-> O_VBUS_EN &&
    O_ORIENT_B && !O_VCONN_B_EN) and (O_VCONN_B_EN |-> O_VBUS_EN &&
    !O_ORIENT_B)) else $error("supply on wrong line");
  a_open_no_power: assert property ((O_LINE_A_CODE == LINE_OPEN &&
    O_LINE_B_CODE == LINE_OPEN) |=> !O_VBUS_EN && !O_ATTACHED)
    else $error("power with both lines open");
  a_ra_decode: assert property (I_LINE_A_BELOW_CABLE[*4]
    |=> O_LINE_A_CODE == LINE_RA) else $error("cable code missing");
  a_rd_decode: assert property ((I_LINE_B_BELOW_SINK &&
    !I_LINE_B_BELOW_CABLE)[*4] |=> O_LINE_B_CODE == LINE_RD)
    else $error("sink code missing");
  a_pullup_map: assert property ($stable(I_ADV_CURRENT)[*3]
    |=> O_PULLUP_SELECT == ($past(I_ADV_CURRENT) == 2'h3 ? ADV_DEFAULT
    : $past(I_ADV_CURRENT))) else $error("pull-up select wrong");
  a_peak_follow: assert property (!$past(I_RST) |->
    O_TX_PEAK_LEVEL == $past(I_TX_PEAK_LEVEL)) else $error("peak level");
  a_ready_idle: assert property ((O_TX_READY && !O_TX_BUSY)
    |-> O_VBUS_EN && !O_RX_ACTIVE) else $error("ready without sink");
endmodule // pd_cc_checker

bind pd_bmc_phy_dfp_attach pd_cc_checker pd_cc_checker_inst (
  .I_CLOCK, .I_RST, .I_ADV_CURRENT, .I_TX_PEAK_LEVEL,
  .I_LINE_A_BELOW_CABLE, .I_LINE_B_BELOW_SINK, .I_LINE_B_BELOW_CABLE,
  .O_TX_READY, .O_TX_BUSY, .O_RX_ACTIVE, .O_LINE_A_TX, .O_LINE_A_TX_OE,
  .O_LINE_B_TX_OE, .O_TX_PEAK_LEVEL, .O_PULLUP_SELECT, .O_VBUS_EN,
  .O_VCONN_A_EN, .O_VCONN_B_EN, .O_ORIENT_B, .O_ATTACHED,
  .O_LINE_A_CODE, .O_LINE_B_CODE);

// >>> dv/pd_cc_far_end.sv
// Far end of the cable: line terminations and the shared coded line.
`timescale 1ns/1ps
module pd_cc_far_end
  import pd_cc_pkg::*;
(
  // Terminations, 0 open, 1 Ra, 2 Rd
  input  wire logic [1:0] term_a,
  input  wire logic [1:0] term_b,
  // Device drivers
  input  wire logic       tx_a,
  input  wire logic       oe_a,
  input  wire logic       tx_b,
  input  wire logic       oe_b,
  // Far-end sender, seen while the device's drivers are off
  input  wire logic       far_en,
  input  wire logic       far_lvl,
  // Comparators and receive lines
  output logic            sink_a,
  output logic            cable_a,
  output logic            sink_b,
  output logic            cable_b,
  output logic            rx_a,
  output logic            rx_b
);
  // Ra pulls the line below both thresholds, Rd only below the sink one.
  assign cable_a = (term_a == LINE_RA);
  assign sink_a  = (term_a != LINE_OPEN);
  assign cable_b = (term_b == LINE_RA);
  assign sink_b  = (term_b != LINE_OPEN);
  // A released line returns to the bias level unless this end sends.
  assign rx_a    = oe_a ? tx_a : (far_en ? far_lvl : 1'b1);
  assign rx_b    = oe_b ? tx_b : (far_en ? far_lvl : 1'b1);
endmodule // pd_cc_far_end

// >>> dv/test_pd_bmc_phy_dfp_attach.sv
// Self-checking bench for the CC transceiver and attach detector.
`timescale 1ns/1ps
module test_pd_bmc_phy_dfp_attach;
  import pd_cc_pkg::*;
  logic I_CLOCK = 1'b0, I_RST = 1'b1, I_TX_VALID = 1'b0;
  logic I_TX_DATA = 1'b0, I_TX_LAST = 1'b0;
  logic [1:0] I_ADV_CURRENT = 2'h0, term_a = 2'h0, term_b = 2'h0;
  logic [3:0] I_TX_PEAK_LEVEL = 4'h0;
  logic I_LINE_A_BELOW_SINK, I_LINE_A_BELOW_CABLE, I_LINE_A_RX;
  logic I_LINE_B_BELOW_SINK, I_LINE_B_BELOW_CABLE, I_LINE_B_RX;
  logic O_TX_READY, O_TX_BUSY, O_RX_VALID, O_RX_DATA, O_RX_ACTIVE;
  logic O_LINE_A_TX, O_LINE_A_TX_OE, O_LINE_B_TX, O_LINE_B_TX_OE;
  logic O_VBUS_EN, O_VCONN_A_EN, O_VCONN_B_EN, O_ORIENT_B, O_ATTACHED;
  logic [3:0] O_TX_PEAK_LEVEL;
  logic [1:0] O_PULLUP_SELECT, O_LINE_A_CODE, O_LINE_B_CODE;
  int num_errors = 0, checks_done = 0, st = 0;
  int from_idle[9] = '{0, 4, 2, 3, 8, 6, 1, 5, 7};
  logic [31:0] seed = 32'h89f789e7;
  logic rxq[$], txq[$];
  logic far_en = 1'b0, far_lvl = 1'b1;
  int seq[8] = '{0, 8, 6, 0, 4, 3, 0, 7};

  pd_bmc_phy_dfp_attach pd_bmc_phy_dfp_attach_inst (
    .I_CLOCK, .I_RST, .I_ADV_CURRENT, .I_TX_PEAK_LEVEL,
    .I_LINE_A_BELOW_SINK, .I_LINE_A_BELOW_CABLE, .I_LINE_B_BELOW_SINK,
    .I_LINE_B_BELOW_CABLE, .I_LINE_A_RX, .I_LINE_B_RX, .I_TX_VALID,
    .I_TX_DATA, .I_TX_LAST, .O_TX_READY, .O_TX_BUSY, .O_RX_VALID,
    .O_RX_DATA, .O_RX_ACTIVE, .O_LINE_A_TX, .O_LINE_A_TX_OE, .O_LINE_B_TX,
    .O_LINE_B_TX_OE, .O_TX_PEAK_LEVEL, .O_PULLUP_SELECT, .O_VBUS_EN,
    .O_VCONN_A_EN, .O_VCONN_B_EN, .O_ORIENT_B, .O_ATTACHED, .O_LINE_A_CODE,
    .O_LINE_B_CODE);
  pd_cc_far_end pd_cc_far_end_inst (
    .term_a(term_a), .term_b(term_b), .tx_a(O_LINE_A_TX),
    .oe_a(O_LINE_A_TX_OE), .tx_b(O_LINE_B_TX), .oe_b(O_LINE_B_TX_OE),
    .sink_a(I_LINE_A_BELOW_SINK), .cable_a(I_LINE_A_BELOW_CABLE),
    .sink_b(I_LINE_B_BELOW_SINK), .cable_b(I_LINE_B_BELOW_CABLE),
    .rx_a(I_LINE_A_RX), .rx_b(I_LINE_B_RX), .far_en(far_en),
    .far_lvl(far_lvl));

  always #5 I_CLOCK = ~I_CLOCK;
  always @(negedge I_CLOCK) if (O_RX_VALID === 1'b1) rxq.push_back(O_RX_DATA);

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Attach model: 0 idle, 1/2 sink, 3/4 cable, 5/6 powered, 7 debug, 8 audio.
  function automatic int nxt(input int s, input int a, input int b);
    if (s == 0) return from_idle[a * 3 + b];
    if (s == 3) return (a == 0) ? 0 : (b == 2) ? 6 : 3;
    if (s == 4) return (b == 0) ? 0 : (a == 2) ? 5 : 4;
    if (s == 1 || s == 5) return (a == 0) ? 0 : s;
    if (s == 2 || s == 6) return (b == 0) ? 0 : s;
    return (a == 0 || b == 0) ? 0 : s;
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic attach_step(input int a, input int b);
    logic [11:0] exp;
    term_a = 2'(a);
    term_b = 2'(b);
    st = nxt(st, a, b);
    // A detach is followed at once by a fresh look from the idle state.
    if (st == 0) st = nxt(0, a, b);
    exp = {3'h0, st != 0, st inside {1, 2, 5, 6}, st == 6, st == 5,
           st inside {2, 3, 6}, 2'(a), 2'(b)};
    repeat (8) @(negedge I_CLOCK);
    chk({3'h0, O_ATTACHED, O_VBUS_EN, O_VCONN_A_EN, O_VCONN_B_EN,
         O_ORIENT_B && st < 7, O_LINE_A_CODE, O_LINE_B_CODE}, exp);
  endtask

  // Own frame loops back through the far end into the receiver.
  task automatic frame(input int n);
    int w;
    txq.delete();
    rxq.delete();
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      I_TX_VALID = 1'b1;
      I_TX_DATA = seed[0];
      I_TX_LAST = (i == n - 1);
      txq.push_back(seed[0]);
      w = 0;
      while (!O_TX_READY && w < 999) begin
        @(negedge I_CLOCK);
        w++;
      end
      @(negedge I_CLOCK);
    end
    I_TX_VALID = 1'b0;
    repeat (1200) @(negedge I_CLOCK);
    chk(12'(rxq.size()), 12'(n));
    foreach (txq[k]) chk({11'h0, rxq[k]}, {11'h0, txq[k]});
  endtask

  // Far end sends n bits with its first edge lost; bit 0 is a zero and
  // goes with it, so n - 1 bits must come out.
  task automatic remote_frame(input int n);
    logic bit_val;
    txq.delete();
    rxq.delete();
    far_en = 1'b1;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      bit_val = (i > 0) && seed[0];
      if (i > 0) begin
        far_lvl = ~far_lvl;
        txq.push_back(bit_val);
      end
      repeat (HALF_BIT_CYC) @(negedge I_CLOCK);
      if (bit_val) far_lvl = ~far_lvl;
      repeat (HALF_BIT_CYC) @(negedge I_CLOCK);
    end
    far_lvl = ~far_lvl;
    repeat (HALF_BIT_CYC) @(negedge I_CLOCK);
    far_en = 1'b0;
    far_lvl = 1'b1;
    repeat (700) @(negedge I_CLOCK);
    chk(12'(rxq.size()), 12'(n - 1));
    foreach (txq[k]) chk({11'h0, rxq[k]}, {11'h0, txq[k]});
  endtask

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge I_CLOCK);
    chk({O_TX_PEAK_LEVEL, O_VBUS_EN, O_ATTACHED, O_TX_BUSY, O_TX_READY},
        12'h080);
    @(negedge I_CLOCK);
    I_RST = 1'b0;
    for (int v = 0; v < 4; v++) begin
      seed = xs(seed);
      I_ADV_CURRENT = 2'(v);
      I_TX_PEAK_LEVEL = seed[3:0];
      repeat (4) @(negedge I_CLOCK);
      chk(12'(O_PULLUP_SELECT), (v == 3) ? 12'h000 : 12'(v));
      chk(12'(O_TX_PEAK_LEVEL), 12'(seed[3:0]));
    end
    attach_step(2, 0);
    frame(9);
    remote_frame(9);
    attach_step(0, 0);
    attach_step(0, 2);
    frame(9);
    // Both lines at once reach the debug, audio and S_POWERED_A states directly.
    foreach (seq[k]) attach_step(seq[k] / 3, seq[k] % 3);
    // One line changes per step, so the model never meets a tie.
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      if (seed[8]) attach_step(int'(seed[1:0]) % 3, int'(term_b));
      else attach_step(int'(term_a), int'(seed[1:0]) % 3);
    end
    conclude();
  end

  // Expected run is under 15000 cycles; this bound leaves a wide margin.
  initial begin
    #500000;
    num_errors++;
    conclude();
  end
endmodule // test_pd_bmc_phy_dfp_attach

// >>> hw/pd_bmc_phy_dfp_attach.sv
// Coded-line transceiver and source-side attach detector for two CC lines.
`timescale 1ns/1ps
module pd_bmc_phy_dfp_attach (
  // Clock and reset
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_RST,
  // Configuration from firmware
  input  wire logic [pd_cc_pkg::ADV_W-1:0]   I_ADV_CURRENT,
  input  wire logic [pd_cc_pkg::TX_PEAK_W-1:0] I_TX_PEAK_LEVEL,
  // Threshold comparators, high when line is below threshold
  input  wire logic                          I_LINE_A_BELOW_SINK,
  input  wire logic                          I_LINE_A_BELOW_CABLE,
  input  wire logic                          I_LINE_B_BELOW_SINK,
  input  wire logic                          I_LINE_B_BELOW_CABLE,
  // Receive comparators
  input  wire logic                          I_LINE_A_RX,
  input  wire logic                          I_LINE_B_RX,
  // Transmit bit stream
  input  wire logic                          I_TX_VALID,
  input  wire logic                          I_TX_DATA,
  input  wire logic                          I_TX_LAST,
  output logic                               O_TX_READY,
  output logic                               O_TX_BUSY,
  // Received bit stream
  output logic                               O_RX_VALID,
  output logic                               O_RX_DATA,
  output logic                               O_RX_ACTIVE,
  // Line drivers
  output logic                               O_LINE_A_TX,
  output logic                               O_LINE_A_TX_OE,
  output logic                               O_LINE_B_TX,
  output logic                               O_LINE_B_TX_OE,
  output logic [pd_cc_pkg::TX_PEAK_W-1:0]    O_TX_PEAK_LEVEL,
  // Pull-up and threshold selection
  output logic [pd_cc_pkg::ADV_W-1:0]        O_PULLUP_SELECT,
  // Power and status
  output logic                               O_VBUS_EN,
  output logic                               O_VCONN_A_EN,
  output logic                               O_VCONN_B_EN,
  output logic                               O_ORIENT_B,
  output logic                               O_ATTACHED,
  output logic [1:0]                         O_LINE_A_CODE,
  output logic [1:0]                         O_LINE_B_CODE
);
  import pd_cc_pkg::*;

  function automatic line_code_t decode_line(input logic below_sink,
                                             input logic below_cable);
    line_code_t code;
    code = LINE_OPEN;
    if (below_cable) begin
      code = LINE_RA;
    end else if (below_sink) begin
      code = LINE_RD;
    end
    return code;
  endfunction

  // Comparator synchronisers.
  logic [CMP_W-1:0] cmp_meta;
  logic [CMP_W-1:0] cmp_sync;
  wire  [CMP_W-1:0] cmp_raw = {I_LINE_B_RX, I_LINE_A_RX,
                               I_LINE_B_BELOW_CABLE, I_LINE_B_BELOW_SINK,
                               I_LINE_A_BELOW_CABLE, I_LINE_A_BELOW_SINK};

  // The synchronisers keep sampling through reset, so the receive lines
  // are settled at release and no false edge opens a frame.
  always_ff @(posedge I_CLOCK) begin
    cmp_meta <= cmp_raw;
    cmp_sync <= cmp_meta;
  end

  // The advertised level selects the pull-up and, with it, which
  // thresholds the comparators report against.
  logic [ADV_W-1:0] adv_level;
  logic [TX_PEAK_W-1:0] tx_peak;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      adv_level <= ADV_DEFAULT;
      tx_peak   <= TX_PEAK_RESET;
    end else begin
      adv_level <= (I_ADV_CURRENT == ADV_1P5 || I_ADV_CURRENT == ADV_3P0)
                   ? I_ADV_CURRENT : ADV_DEFAULT;
      tx_peak   <= I_TX_PEAK_LEVEL;
    end
  end

  line_code_t code_a;
  line_code_t code_b;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      code_a <= LINE_OPEN;
      code_b <= LINE_OPEN;
    end else begin
      code_a <= decode_line(cmp_sync[CMP_A_SINK], cmp_sync[CMP_A_CABLE]);
      code_b <= decode_line(cmp_sync[CMP_B_SINK], cmp_sync[CMP_B_CABLE]);
    end
  end

  // Attach state machine.
  attach_state_t state;
  attach_state_t next_state;
  wire a_open = (code_a == LINE_OPEN);
  wire b_open = (code_b == LINE_OPEN);
  wire a_ra   = (code_a == LINE_RA);
  wire b_ra   = (code_b == LINE_RA);
  wire a_rd   = (code_a == LINE_RD);
  wire b_rd   = (code_b == LINE_RD);

  always_comb begin
    next_state = state;
    unique case (state)
      S_UNATTACHED: begin
        if (a_rd && b_rd) begin
          next_state = S_DEBUG;
        end else if (a_ra && b_ra) begin
          next_state = S_AUDIO;
        end else if (a_rd && b_ra) begin
          next_state = S_POWERED_A;
        end else if (a_ra && b_rd) begin
          next_state = S_POWERED_B;
        end else if (a_rd) begin
          next_state = S_SINK_A;
        end else if (b_rd) begin
          next_state = S_SINK_B;
        end else if (a_ra) begin
          next_state = S_CABLE_A;
        end else if (b_ra) begin
          next_state = S_CABLE_B;
        end
      end
      S_SINK_A: if (a_open) next_state = S_UNATTACHED;
      S_SINK_B: if (b_open) next_state = S_UNATTACHED;
      S_CABLE_A: begin
        if (a_open) begin
          next_state = S_UNATTACHED;
        end else if (b_rd) begin
          next_state = S_POWERED_B;
        end
      end
      S_CABLE_B: begin
        if (b_open) begin
          next_state = S_UNATTACHED;
        end else if (a_rd) begin
          next_state = S_POWERED_A;
        end
      end
      // Only the sink line is watched; the cable line is ignored here.
      S_POWERED_A: if (a_open) next_state = S_UNATTACHED;
      S_POWERED_B: if (b_open) next_state = S_UNATTACHED;
      S_DEBUG, S_AUDIO: begin
        if (a_open || b_open) begin
          next_state = S_UNATTACHED;
        end
      end
      default: next_state = S_UNATTACHED;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state <= S_UNATTACHED;
    end else begin
      state <= next_state;
    end
  end

  wire sink_present = (state == S_SINK_A) || (state == S_SINK_B)
                    || (state == S_POWERED_A) || (state == S_POWERED_B);
  wire next_vbus    = (next_state == S_SINK_A) || (next_state == S_SINK_B)
                    || (next_state == S_POWERED_A)
                    || (next_state == S_POWERED_B);
  wire next_orient  = (next_state == S_SINK_B) || (next_state == S_POWERED_B)
                    || (next_state == S_CABLE_A);

  logic vbus_en;
  logic vconn_a;
  logic vconn_b;
  logic orient_b;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      vbus_en  <= 1'b0;
      vconn_a  <= 1'b0;
      vconn_b  <= 1'b0;
      orient_b <= 1'b0;
    end else begin
      vbus_en  <= next_vbus;
      vconn_a  <= (next_state == S_POWERED_B);
      vconn_b  <= (next_state == S_POWERED_A);
      orient_b <= next_orient;
    end
  end

  // Receiver on the selected line.
  wire rx_line = orient_b ? cmp_sync[CMP_B_RX] : cmp_sync[CMP_A_RX];
  logic             rx_prev;
  logic [CNT_W-1:0] rx_cnt;
  logic             rx_half;
  logic             rx_frame;
  logic             rx_valid;
  logic             rx_data;
  wire rx_edge     = (rx_line != rx_prev);
  wire rx_boundary = rx_edge && (rx_cnt >= THREE_Q_CNT);
  wire rx_mid      = rx_edge && !rx_boundary && (rx_cnt >= QUARTER_CNT);
  wire rx_timeout  = (rx_cnt >= TIMEOUT_CNT);

  // A frame opens on whatever edge is seen first, so a lost first edge
  // only costs one preamble bit.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rx_prev  <= rx_line;
      rx_cnt   <= CNT_ZERO;
      rx_half  <= 1'b0;
      rx_frame <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 1'b0;
    end else begin
      rx_prev  <= rx_line;
      rx_valid <= rx_boundary && rx_frame;
      if (rx_boundary) begin
        rx_data <= rx_half;
      end
      if (rx_edge && !rx_frame) begin
        rx_frame <= 1'b1;
        rx_cnt   <= CNT_ZERO;
        rx_half  <= 1'b0;
      end else if (rx_boundary) begin
        rx_cnt  <= CNT_ZERO;
        rx_half <= 1'b0;
      end else begin
        if (rx_mid) begin
          rx_half <= 1'b1;
        end
        if (rx_timeout) begin
          rx_frame <= 1'b0;
        end else begin
          rx_cnt <= rx_cnt + CNT_ONE;
        end
      end
    end
  end

  // Transmitter.
  tx_state_t        tx_state;
  tx_state_t        next_tx_state;
  logic [CNT_W-1:0] tx_cnt;
  logic             tx_level;
  logic             tx_bit;
  logic             tx_last;
  wire half_done = (tx_cnt == HALF_LAST);
  // Start only toward a sink and while the far end is silent.
  wire tx_allowed = sink_present && !rx_frame;
  wire take_bit   = I_TX_VALID && O_TX_READY;

  assign O_TX_READY = ((tx_state == T_IDLE) && tx_allowed)
                    || ((tx_state == T_SECOND) && half_done && !tx_last);

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      T_IDLE:   if (take_bit) next_tx_state = T_FIRST;
      T_FIRST:  if (half_done) next_tx_state = T_SECOND;
      T_SECOND: begin
        if (half_done) begin
          next_tx_state = take_bit ? T_FIRST : T_CLOSE;
        end
      end
      T_CLOSE:  if (half_done) next_tx_state = T_IDLE;
      default:  next_tx_state = T_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      tx_state <= T_IDLE;
      tx_cnt   <= CNT_ZERO;
      tx_level <= 1'b0;
      tx_bit   <= 1'b0;
      tx_last  <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt   <= (tx_state == T_IDLE || half_done) ? CNT_ZERO
                                                    : tx_cnt + CNT_ONE;
      if (take_bit) begin
        tx_bit  <= I_TX_DATA;
        tx_last <= I_TX_LAST;
      end
      if (tx_state == T_IDLE) begin
        tx_level <= 1'b0;
      end else if (half_done) begin
        if (tx_state == T_FIRST) begin
          tx_level <= tx_level ^ tx_bit;
        end else if (tx_state == T_SECOND) begin
          tx_level <= ~tx_level;
        end
      end
    end
  end

  wire tx_drive = (tx_state != T_IDLE);

  assign O_TX_BUSY       = tx_drive;
  assign O_RX_VALID      = rx_valid;
  assign O_RX_DATA       = rx_data;
  assign O_RX_ACTIVE     = rx_frame;
  assign O_LINE_A_TX     = tx_level;
  assign O_LINE_B_TX     = tx_level;
  assign O_LINE_A_TX_OE  = tx_drive && !orient_b;
  assign O_LINE_B_TX_OE  = tx_drive && orient_b;
  assign O_TX_PEAK_LEVEL = tx_peak;
  assign O_PULLUP_SELECT = adv_level;
  assign O_VBUS_EN       = vbus_en;
  assign O_VCONN_A_EN    = vconn_a;
  assign O_VCONN_B_EN    = vconn_b;
  assign O_ORIENT_B      = orient_b;
  assign O_ATTACHED      = (state != S_UNATTACHED);
  assign O_LINE_A_CODE   = code_a;
  assign O_LINE_B_CODE   = code_b;

endmodule // pd_bmc_phy_dfp_attach

// >>> hw/pd_cc_pkg.sv
// Constants and types for the configuration-channel link and attach logic.
// Notes on behaviour
// - Transition every bit start, mid-bit for ones.
// - Transmitted preamble begins at low level.
// - Closing edge after final end-of-packet bit.
// - Receiver tolerates losing the first preamble edge.
// - Data only on orientation-selected line.
// - Driver enabled only while transmitting.
// - Only one party drives the line.
// - Transmit peak level adjustable by firmware.
// - Both open: monitor both, no power.
// - Rd plus open: VBUS only, watch Rd.
// - Ra plus open: no power, watch both.
// - Ra plus Rd: VBUS, VCONN on Ra.
// - Rd/Rd debug, Ra/Ra audio; either detaches.
// - Advertise default, 1.5 A or 3 A.
// - Below sink threshold means Rd.
// - Below active-cable threshold means Ra.
// - Rise above sink threshold is detach.
package pd_cc_pkg;

  // Timing of the coded line.
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_BIT_NS   = 1667;
  localparam int HALF_BIT_CYC  = HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 10;

  localparam logic [CNT_W-1:0] HALF_LAST    = CNT_W'(HALF_BIT_CYC - 1);
  localparam logic [CNT_W-1:0] QUARTER_CNT  = CNT_W'(HALF_BIT_CYC / 2);
  localparam logic [CNT_W-1:0] THREE_Q_CNT  = CNT_W'(HALF_BIT_CYC
                                                     + HALF_BIT_CYC / 2);
  localparam logic [CNT_W-1:0] TIMEOUT_CNT  = CNT_W'(3 * HALF_BIT_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO     = '0;
  localparam logic [CNT_W-1:0] CNT_ONE      = CNT_W'(1);

  // Advertised source current.
  localparam int ADV_W = 2;
  localparam logic [ADV_W-1:0] ADV_DEFAULT = 2'h0;
  localparam logic [ADV_W-1:0] ADV_1P5     = 2'h1;
  localparam logic [ADV_W-1:0] ADV_3P0     = 2'h2;

  // Transmit peak level setting.
  localparam int TX_PEAK_W = 4;
  localparam logic [TX_PEAK_W-1:0] TX_PEAK_RESET = 4'h8;

  // Comparator vector layout.
  localparam int CMP_W        = 6;
  localparam int CMP_A_SINK   = 0;
  localparam int CMP_A_CABLE  = 1;
  localparam int CMP_B_SINK   = 2;
  localparam int CMP_B_CABLE  = 3;
  localparam int CMP_A_RX     = 4;
  localparam int CMP_B_RX     = 5;

  typedef enum logic [1:0] {
    LINE_OPEN = 2'h0,
    LINE_RA   = 2'h1,
    LINE_RD   = 2'h2
  } line_code_t;

  typedef enum logic [8:0] {
    S_UNATTACHED = 9'h001,
    S_SINK_A     = 9'h002,
    S_SINK_B     = 9'h004,
    S_CABLE_A    = 9'h008,
    S_CABLE_B    = 9'h010,
    S_POWERED_A  = 9'h020,
    S_POWERED_B  = 9'h040,
    S_DEBUG      = 9'h080,
    S_AUDIO      = 9'h100
  } attach_state_t;

  typedef enum logic [3:0] {
    T_IDLE   = 4'h1,
    T_FIRST  = 4'h2,
    T_SECOND = 4'h4,
    T_CLOSE  = 4'h8
  } tx_state_t;

endpackage
